//--- pkg/dpc_defines.vh
// Purpose: constants for the dual port pulse input counter
// Assumes: register offsets are holding register indices from base 40001
// Notes: one 16-bit word per register
`ifndef DPC_DEFINES_VH
`define DPC_DEFINES_VH

`define DPC_HOLDING_BASE 40001
`define DPC_AW 16
`define DPC_DW 16

// register offsets
`define DPC_OFF_P1_LEVEL 16'h112F
`define DPC_OFF_P2_LEVEL 16'h1130
`define DPC_OFF_P1_MODE 16'h13EB
`define DPC_OFF_P1_TALLY_LO 16'h13EC
`define DPC_OFF_P1_TALLY_HI 16'h13ED
`define DPC_OFF_P1_SCALE_WHOLE 16'h13EE
`define DPC_OFF_P1_SCALE_THOU 16'h13EF
`define DPC_OFF_P1_PULSE_OUT_CFG 16'h13F5
`define DPC_OFF_P2_MODE 16'h144F
`define DPC_OFF_P2_TALLY_LO 16'h1450
`define DPC_OFF_P2_TALLY_HI 16'h1451
`define DPC_OFF_P2_SCALE_WHOLE 16'h1452
`define DPC_OFF_P2_SCALE_THOU 16'h1453
`define DPC_OFF_P2_PULSE_OUT_CFG 16'h1459

// edge modes
`define DPC_MODE_OFF 2'h0
`define DPC_MODE_RISE 2'h1
`define DPC_MODE_FALL 2'h2
`define DPC_MODE_BOTH 2'h3
`define DPC_MODE_MAX 16'h0003

// reset values
`define DPC_RST_WORD 16'h0000
`define DPC_RST_SCALE_WHOLE 16'h0001
`define DPC_RST_TALLY 32'h0000_0000
`define DPC_RST_PIN 1'b1

// scale fraction: thousandths
`define DPC_THOU_W 10
`define DPC_THOU_ONE 11'h3E8
`define DPC_THOU_MAX 10'h3E7
`define DPC_RST_THOU 10'h000

`endif

//--- src/dpc_port_counter.v
// Purpose: one port: input synchroniser, edge select, scaled accumulator
// Assumes: pin is asynchronous to CLK_SYS; thousandths already limited to 0..999
// Notes: fraction below one count is kept in a residue register
`timescale 1ns/1ps
`default_nettype none
`include "dpc_defines.vh"

module dpc_port_counter (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // pin
  input wire pin_in,
  // configuration
  input wire [1:0] mode,
  input wire [15:0] scale_whole,
  input wire [`DPC_THOU_W-1:0] scale_thou,
  // state
  output reg level_r,
  output reg [31:0] tally_r
);

  reg sync1_r;
  reg prev_r;
  reg [`DPC_THOU_W-1:0] residue_r;
  reg [`DPC_THOU_W-1:0] residue_nxt;
  reg [31:0] tally_nxt;
  reg count_hit;
  reg [`DPC_THOU_W:0] frac_sum;
  reg [`DPC_THOU_W:0] frac_left;
  wire rise;
  wire fall;

  assign rise = level_r & ~prev_r;
  assign fall = ~level_r & prev_r;

  always @* begin
    case (mode)
      `DPC_MODE_OFF: count_hit = 1'b0;
      `DPC_MODE_RISE: count_hit = rise;
      `DPC_MODE_FALL: count_hit = fall;
      `DPC_MODE_BOTH: count_hit = rise | fall;
      default: count_hit = 1'b0;
    endcase
  end

  // whole part plus carry out of the thousandths residue
  always @* begin
    frac_sum = {1'b0, residue_r} + {1'b0, scale_thou};
    frac_left = frac_sum - `DPC_THOU_ONE;
    residue_nxt = residue_r;
    tally_nxt = tally_r;
    if (count_hit) begin
      if (frac_sum >= `DPC_THOU_ONE) begin
        residue_nxt = frac_left[`DPC_THOU_W-1:0];
        tally_nxt = tally_r + {16'h0000, scale_whole} + 32'h0000_0001;
      end else begin
        residue_nxt = frac_sum[`DPC_THOU_W-1:0];
        tally_nxt = tally_r + {16'h0000, scale_whole};
      end
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= `DPC_RST_PIN;
      level_r <= `DPC_RST_PIN;
      prev_r <= `DPC_RST_PIN;
      residue_r <= `DPC_RST_THOU;
      tally_r <= `DPC_RST_TALLY;
    end else begin
      sync1_r <= pin_in;
      level_r <= sync1_r;
      prev_r <= level_r;
      residue_r <= residue_nxt;
      tally_r <= tally_nxt;
    end
  end

endmodule // dpc_port_counter
`default_nettype wire

//--- src/dpc_top.v
// Purpose: dual digital I/O port status and scaled pulse input counter
// Assumes: register port is a word-wide holding register access, one access per cycle
// Notes: pulse output generation itself lives elsewhere; only its enable is shown here
// Behaviour
// - each port status register reads 0 for a low input (closed) and 1 for high (open).
// - edge mode 0 on a port stops all counting on that port.
// - mode 1 counts rising edges, mode 2 falling edges, mode 3 both.
// - any counting mode turns the port's pulse output function off.
// - writing a nonzero edge mode clears that port's pulse output configuration to zero.
// - with counting off and a zero pulse output configuration the port is free for plain I/O control.
// - each port's accumulator reads as a low word then a high word at the next offset.
// - scale factor equals the whole register plus the thousandths register over 1000.
// - offsets are holding register indices from base 40001, one 16-bit word each.
`timescale 1ns/1ps
`default_nettype none
`include "dpc_defines.vh"

module dpc_top (
  // clock and reset
  input wire CLK_SYS,
  input wire ARST_N,
  // port pins
  input wire PORT1_PIN,
  input wire PORT2_PIN,
  // holding register access
  input wire [`DPC_AW-1:0] REG_ADDR,
  input wire REG_WR,
  input wire [`DPC_DW-1:0] REG_WDATA,
  input wire REG_RD,
  output reg [`DPC_DW-1:0] REG_RDATA,
  output reg REG_RVALID,
  output reg REG_HIT,
  // port function status
  output reg PORT1_PULSE_OUT_EN,
  output reg PORT2_PULSE_OUT_EN,
  output reg PORT1_IO_CTRL_EN,
  output reg PORT2_IO_CTRL_EN
);

  reg rst_meta_r;
  reg rst_sync_r;
  wire rst_n;

  reg [`DPC_DW-1:0] p1_mode_r;
  reg [`DPC_DW-1:0] p2_mode_r;
  reg [`DPC_DW-1:0] p1_whole_r;
  reg [`DPC_DW-1:0] p2_whole_r;
  reg [`DPC_THOU_W-1:0] p1_thou_r;
  reg [`DPC_THOU_W-1:0] p2_thou_r;
  reg [`DPC_DW-1:0] p1_out_cfg_r;
  reg [`DPC_DW-1:0] p2_out_cfg_r;
  reg [`DPC_DW-1:0] p1_hi_snap_r;
  reg [`DPC_DW-1:0] p2_hi_snap_r;

  reg [`DPC_DW-1:0] rdata_nxt;
  reg hit_nxt;
  reg [`DPC_THOU_W-1:0] wthou;
  reg [1:0] p1_edge;
  reg [1:0] p2_edge;

  wire p1_level;
  wire p2_level;
  wire [31:0] p1_tally;
  wire [31:0] p2_tally;
  wire wr_p1_mode;
  wire wr_p2_mode;

  // reset released through two flops, asserted at once
  always @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end
  assign rst_n = rst_sync_r;

  assign wr_p1_mode = REG_WR && (REG_ADDR == `DPC_OFF_P1_MODE);
  assign wr_p2_mode = REG_WR && (REG_ADDR == `DPC_OFF_P2_MODE);

  // out-of-range mode values are kept as written but count nothing
  always @* begin
    p1_edge = (p1_mode_r <= `DPC_MODE_MAX) ? p1_mode_r[1:0] : `DPC_MODE_OFF;
    p2_edge = (p2_mode_r <= `DPC_MODE_MAX) ? p2_mode_r[1:0] : `DPC_MODE_OFF;
  end

  // thousandths saturate at 999 so one edge carries at most one whole count
  always @* begin
    if (REG_WDATA > {6'h00, `DPC_THOU_MAX}) begin
      wthou = `DPC_THOU_MAX;
    end else begin
      wthou = REG_WDATA[`DPC_THOU_W-1:0];
    end
  end

  // writable registers
  always @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      p1_mode_r <= `DPC_RST_WORD;
      p2_mode_r <= `DPC_RST_WORD;
      p1_whole_r <= `DPC_RST_SCALE_WHOLE;
      p2_whole_r <= `DPC_RST_SCALE_WHOLE;
      p1_thou_r <= `DPC_RST_THOU;
      p2_thou_r <= `DPC_RST_THOU;
      p1_out_cfg_r <= `DPC_RST_WORD;
      p2_out_cfg_r <= `DPC_RST_WORD;
    end else begin
      if (wr_p1_mode) begin
        p1_mode_r <= REG_WDATA;
      end
      if (wr_p2_mode) begin
        p2_mode_r <= REG_WDATA;
      end
      if (REG_WR && REG_ADDR == `DPC_OFF_P1_SCALE_WHOLE) begin
        p1_whole_r <= REG_WDATA;
      end
      if (REG_WR && REG_ADDR == `DPC_OFF_P2_SCALE_WHOLE) begin
        p2_whole_r <= REG_WDATA;
      end
      if (REG_WR && REG_ADDR == `DPC_OFF_P1_SCALE_THOU) begin
        p1_thou_r <= wthou;
      end
      if (REG_WR && REG_ADDR == `DPC_OFF_P2_SCALE_THOU) begin
        p2_thou_r <= wthou;
      end
      // nonzero mode write wins over a same-cycle config write
      if (wr_p1_mode && REG_WDATA != `DPC_RST_WORD) begin
        p1_out_cfg_r <= `DPC_RST_WORD;
      end else if (REG_WR && REG_ADDR == `DPC_OFF_P1_PULSE_OUT_CFG) begin
        p1_out_cfg_r <= REG_WDATA;
      end
      if (wr_p2_mode && REG_WDATA != `DPC_RST_WORD) begin
        p2_out_cfg_r <= `DPC_RST_WORD;
      end else if (REG_WR && REG_ADDR == `DPC_OFF_P2_PULSE_OUT_CFG) begin
        p2_out_cfg_r <= REG_WDATA;
      end
    end
  end

  dpc_port_counter u_port1 (
    .clk(CLK_SYS),
    .rst_n(rst_n),
    .pin_in(PORT1_PIN),
    .mode(p1_edge),
    .scale_whole(p1_whole_r),
    .scale_thou(p1_thou_r),
    .level_r(p1_level),
    .tally_r(p1_tally)
  );

  dpc_port_counter u_port2 (
    .clk(CLK_SYS),
    .rst_n(rst_n),
    .pin_in(PORT2_PIN),
    .mode(p2_edge),
    .scale_whole(p2_whole_r),
    .scale_thou(p2_thou_r),
    .level_r(p2_level),
    .tally_r(p2_tally)
  );

  // read mux; reading the low word freezes the high word for a coherent pair
  always @* begin
    hit_nxt = 1'b1;
    rdata_nxt = `DPC_RST_WORD;
    case (REG_ADDR)
      `DPC_OFF_P1_LEVEL: rdata_nxt = {15'h0000, p1_level};
      `DPC_OFF_P2_LEVEL: rdata_nxt = {15'h0000, p2_level};
      `DPC_OFF_P1_MODE: rdata_nxt = p1_mode_r;
      `DPC_OFF_P2_MODE: rdata_nxt = p2_mode_r;
      `DPC_OFF_P1_TALLY_LO: rdata_nxt = p1_tally[15:0];
      `DPC_OFF_P1_TALLY_HI: rdata_nxt = p1_hi_snap_r;
      `DPC_OFF_P2_TALLY_LO: rdata_nxt = p2_tally[15:0];
      `DPC_OFF_P2_TALLY_HI: rdata_nxt = p2_hi_snap_r;
      `DPC_OFF_P1_SCALE_WHOLE: rdata_nxt = p1_whole_r;
      `DPC_OFF_P2_SCALE_WHOLE: rdata_nxt = p2_whole_r;
      `DPC_OFF_P1_SCALE_THOU: rdata_nxt = {6'h00, p1_thou_r};
      `DPC_OFF_P2_SCALE_THOU: rdata_nxt = {6'h00, p2_thou_r};
      `DPC_OFF_P1_PULSE_OUT_CFG: rdata_nxt = p1_out_cfg_r;
      `DPC_OFF_P2_PULSE_OUT_CFG: rdata_nxt = p2_out_cfg_r;
      default: hit_nxt = 1'b0;
    endcase
  end

  always @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      REG_RDATA <= `DPC_RST_WORD;
      REG_RVALID <= 1'b0;
      REG_HIT <= 1'b0;
      p1_hi_snap_r <= `DPC_RST_WORD;
      p2_hi_snap_r <= `DPC_RST_WORD;
    end else begin
      REG_RVALID <= REG_RD;
      if (REG_RD) begin
        REG_RDATA <= rdata_nxt;
        REG_HIT <= hit_nxt;
        if (REG_ADDR == `DPC_OFF_P1_TALLY_LO) begin
          p1_hi_snap_r <= p1_tally[31:16];
        end
        if (REG_ADDR == `DPC_OFF_P2_TALLY_LO) begin
          p2_hi_snap_r <= p2_tally[31:16];
        end
      end
    end
  end

  // function enables: counting shuts pulse output, counting off with zero pulse config frees I/O control
  always @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      PORT1_PULSE_OUT_EN <= 1'b0;
      PORT2_PULSE_OUT_EN <= 1'b0;
      PORT1_IO_CTRL_EN <= 1'b1;
      PORT2_IO_CTRL_EN <= 1'b1;
    end else begin
      PORT1_PULSE_OUT_EN <= (p1_edge == `DPC_MODE_OFF) && (p1_out_cfg_r != `DPC_RST_WORD);
      PORT2_PULSE_OUT_EN <= (p2_edge == `DPC_MODE_OFF) && (p2_out_cfg_r != `DPC_RST_WORD);
      PORT1_IO_CTRL_EN <= (p1_edge == `DPC_MODE_OFF) && (p1_out_cfg_r == `DPC_RST_WORD);
      PORT2_IO_CTRL_EN <= (p2_edge == `DPC_MODE_OFF) && (p2_out_cfg_r == `DPC_RST_WORD);
    end
  end

endmodule // dpc_top
`default_nettype wire

//--- test/dpc_top_checker.sv
// Purpose: port-level checks on dpc_top
// Assumes: read strobe is one cycle wide
// Notes: bound to the top, sees ports only
`timescale 1ns/1ps
`default_nettype none
`include "dpc_defines.vh"
module dpc_top_checker (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  // pin
  input wire logic PORT1_PIN,
  // register access
  input wire logic [15:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic [15:0] REG_WDATA,
  input wire logic REG_RD,
  input wire logic [15:0] REG_RDATA,
  input wire logic REG_RVALID,
  input wire logic REG_HIT,
  // port function
  input wire logic PORT1_PULSE_OUT_EN,
  input wire logic PORT2_PULSE_OUT_EN,
  input wire logic PORT1_IO_CTRL_EN,
  input wire logic PORT2_IO_CTRL_EN
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!ARST_N);
  sequence m1_s; REG_WR && REG_ADDR == `DPC_OFF_P1_MODE && REG_WDATA inside {[1:3]}; endsequence
  sequence q1_s; !(REG_WR && REG_ADDR == `DPC_OFF_P1_MODE); endsequence
  sequence m2_s; REG_WR && REG_ADDR == `DPC_OFF_P2_MODE && REG_WDATA inside {[1:3]}; endsequence
  sequence q2_s; !(REG_WR && REG_ADDR == `DPC_OFF_P2_MODE); endsequence
  valid_follows_a: assert property (REG_RD |=> REG_RVALID)
    else $error("read got no valid");
  valid_cause_a: assert property (REG_RVALID |-> $past(REG_RD))
    else $error("valid without read");
  unmapped_read_a: assert property (REG_RD && REG_ADDR < 16'h1000 |=> !REG_HIT && REG_RDATA == 16'h0000)
    else $error("unmapped read answered");
  read_hold_a: assert property (!REG_RD |=> $stable(REG_RDATA) && $stable(REG_HIT))
    else $error("read data moved");
  level_read_a: assert property ($stable(PORT1_PIN)[*4] ##0 (REG_RD && REG_ADDR == `DPC_OFF_P1_LEVEL)
    |=> REG_RDATA == {15'h0000, $past(PORT1_PIN)})
    else $error("level read wrong");
  excl_one_a: assert property (!(PORT1_PULSE_OUT_EN && PORT1_IO_CTRL_EN))
    else $error("port1 both functions");
  excl_two_a: assert property (!(PORT2_PULSE_OUT_EN && PORT2_IO_CTRL_EN))
    else $error("port2 both functions");
  mode_one_clear_a: assert property (m1_s ##1 q1_s |=> !PORT1_PULSE_OUT_EN && !PORT1_IO_CTRL_EN)
    else $error("port1 output kept");
  mode_two_clear_a: assert property (m2_s ##1 q2_s |=> !PORT2_PULSE_OUT_EN && !PORT2_IO_CTRL_EN)
    else $error("port2 output kept");
endmodule // dpc_top_checker
bind dpc_top dpc_top_checker dpc_top_checker_inst (.CLK_SYS, .ARST_N, .PORT1_PIN, .REG_ADDR,
  .REG_WR, .REG_WDATA, .REG_RD, .REG_RDATA, .REG_RVALID, .REG_HIT, .PORT1_PULSE_OUT_EN,
  .PORT2_PULSE_OUT_EN, .PORT1_IO_CTRL_EN, .PORT2_IO_CTRL_EN);
`default_nettype wire

//--- test/dpc_contact_model.sv
// Purpose: two clean contacts driving the port pins
// Assumes: one toggle per request
// Notes: dwell of 5 cycles keeps each level well past the synchroniser
`timescale 1ns/1ps
`default_nettype none
module dpc_contact_model (
  // clock
  input wire logic clk,
  // toggle request per port
  input wire logic [1:0] go,
  // contact lines, open at start
  output logic [1:0] pin,
  output wire logic [1:0] busy
);
  logic [3:0] cnt_r [2];
  initial begin
    pin = 2'b11;
    cnt_r[0] = 4'h0;
    cnt_r[1] = 4'h0;
  end
  for (genvar i = 0; i < 2; i++) begin : g_port
    always @(posedge clk) begin
      if (cnt_r[i] != 4'h0) cnt_r[i] <= cnt_r[i] - 4'h1;
      else if (go[i]) begin
        pin[i] <= ~pin[i];
        cnt_r[i] <= 4'h5;
      end
    end
    assign busy[i] = go[i] || cnt_r[i] != 4'h0;
  end
endmodule // dpc_contact_model
`default_nettype wire

//--- test/tb_dpc_top.sv
// Purpose: register-level test of dpc_top
// Assumes: contacts toggle cleanly
// Notes: tally expectations tracked here
`timescale 1ns/1ps
`default_nettype none
`include "dpc_defines.vh"
module tb_dpc_top;
  logic CLK_SYS = 1'b0;
  logic ARST_N = 1'b0;
  logic REG_WR = 1'b0;
  logic REG_RD = 1'b0;
  logic [15:0] REG_ADDR = 16'h0000;
  logic [15:0] REG_WDATA = 16'h0000;
  logic [15:0] REG_RDATA;
  logic REG_RVALID, REG_HIT;
  logic [1:0] go = 2'b00, pin, busy;
  logic [3:0] en;
  logic [31:0] exp1 = 32'h0;
  int miscompares = 0, checks = 0;
  always #2.5 CLK_SYS = ~CLK_SYS;
  dpc_top dpc_top_inst (.CLK_SYS(CLK_SYS), .ARST_N(ARST_N), .PORT1_PIN(pin[0]),
    .PORT2_PIN(pin[1]), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_WDATA(REG_WDATA),
    .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID), .REG_HIT(REG_HIT),
    .PORT1_PULSE_OUT_EN(en[0]), .PORT2_PULSE_OUT_EN(en[1]), .PORT1_IO_CTRL_EN(en[2]),
    .PORT2_IO_CTRL_EN(en[3]));
  dpc_contact_model dpc_contact_model_inst (.clk(CLK_SYS), .go(go), .pin(pin), .busy(busy));
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task automatic close_out;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge CLK_SYS);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge CLK_SYS);
    REG_WR <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    int k;
    @(posedge CLK_SYS);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge CLK_SYS);
    REG_RD <= 1'b0;
    // valid and data are launched at this edge; look once they have settled
    #1;
    for (k = 0; k < 4 && REG_RVALID !== 1'b1; k++) begin
      @(posedge CLK_SYS);
      #1;
    end
    if (k == 4) begin
      chk(16'hDEAD, 16'h0000);
      close_out();
    end else begin
      chk(REG_RDATA, e);
    end
  endtask
  // one contact transition, then wait out the dwell
  task automatic tog(input int p);
    int k;
    @(posedge CLK_SYS);
    go[p] <= 1'b1;
    @(posedge CLK_SYS);
    go[p] <= 1'b0;
    for (k = 0; k < 20 && busy[p] !== 1'b0; k++) @(posedge CLK_SYS);
    if (k == 20) begin
      chk(16'hDEAD, 16'h0000);
      close_out();
    end
  endtask
  initial begin
    int m;
    repeat (20) @(posedge CLK_SYS);
    ARST_N <= 1'b1;
    repeat (6) @(posedge CLK_SYS);
    rd(`DPC_OFF_P1_LEVEL, 16'h0001);
    rd(`DPC_OFF_P1_SCALE_WHOLE, 16'h0001);
    rd(16'h0000, 16'h0000);
    chk({15'h0000, REG_HIT}, 16'h0000);
    chk({12'h000, en}, 16'h000C);
    tog(0);
    rd(`DPC_OFF_P1_LEVEL, 16'h0000);
    tog(0);
    rd(`DPC_OFF_P1_TALLY_LO, 16'h0000);
    wr(`DPC_OFF_P1_PULSE_OUT_CFG, 16'h0001);
    rd(`DPC_OFF_P1_PULSE_OUT_CFG, 16'h0001);
    chk({12'h000, en}, 16'h0009);
    for (m = 1; m < 4; m++) begin
      wr(`DPC_OFF_P1_MODE, m[15:0]);
      if (m == 1) rd(`DPC_OFF_P1_PULSE_OUT_CFG, 16'h0000);
      if (m == 1) chk({12'h000, en}, 16'h0008);
      repeat (4) tog(0);
      exp1 += (m == 3) ? 32'h4 : 32'h2;
      rd(`DPC_OFF_P1_TALLY_LO, exp1[15:0]);
    end
    wr(`DPC_OFF_P1_SCALE_WHOLE, 16'hFFFF);
    wr(`DPC_OFF_P1_SCALE_THOU, 16'h01F4);
    tog(0);
    tog(0);
    rd(`DPC_OFF_P1_TALLY_HI, 16'h0000);
    exp1 += 32'h0001_FFFF;
    rd(`DPC_OFF_P1_TALLY_LO, exp1[15:0]);
    rd(`DPC_OFF_P1_TALLY_HI, exp1[31:16]);
    wr(`DPC_OFF_P1_SCALE_THOU, 16'h05DC);
    rd(`DPC_OFF_P1_SCALE_THOU, 16'h03E7);
    wr(`DPC_OFF_P2_PULSE_OUT_CFG, 16'h0001);
    wr(`DPC_OFF_P2_MODE, 16'h0002);
    rd(`DPC_OFF_P2_PULSE_OUT_CFG, 16'h0000);
    wr(`DPC_OFF_P2_SCALE_WHOLE, 16'h0003);
    tog(1);
    rd(`DPC_OFF_P2_LEVEL, 16'h0000);
    chk({15'h0000, REG_HIT}, 16'h0001);
    tog(1);
    wr(`DPC_OFF_P2_TALLY_LO, 16'h1234);
    rd(`DPC_OFF_P2_TALLY_LO, 16'h0003);
    rd(`DPC_OFF_P2_LEVEL, 16'h0001);
    close_out();
  end
endmodule // tb_dpc_top
`default_nettype wire
